/* tpo_top.sv */
// AXI4-Lite wrapper issuing accumulator-transfer instructions.
// Overview of operation
// - Prescaler load puts B in high nibbles
// - Prescaler load puts A in low nibbles
// - Pull-up load zero copies A to reg0
// - Pull-up load one copies A to reg1
// - Timer1 reload load puts B high
// - Timer1 reload load puts A low
// Assumes a single-clock AXI4-Lite master; software writes A/B then an op.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tpo_defs.svh"
module tpo_top (
	input wire logic aclk, // Clock, 200 MHz
	input wire logic aresetn, // Sync reset, low
	input wire logic [11:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [11:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output tpo_pkg::tpo_regs_type regs, // Timer and pull-up registers
	output logic carry_out // Carry flag, software-owned
);
	import tpo_pkg::*;
	logic aw_held_reg, w_held_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	tpo_work_type work_reg;
	logic carry_reg, skip_reg;
	tpo_op_type op_reg;
	tpo_flags_type flags_o;
	logic done;
	logic [7:0] count_reg;
	logic wr_go;

	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign carry_out = carry_reg;
	assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;

	// Address and data accepted in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	sequence s_write_commit;
		wr_go;
	endsequence

	// A second write must wait until the answer to the first is taken
	a_aw_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		aw_held_reg || bvalid_reg |-> !s_axi_awready)
		else $error("write address accepted while busy");
	a_w_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		w_held_reg || bvalid_reg |-> !s_axi_wready)
		else $error("write data accepted while busy");
	a_commit_frees: assert property (@(posedge aclk) disable iff (!aresetn)
		s_write_commit |=> !aw_held_reg && !w_held_reg && s_axi_bvalid)
		else $error("write commit did not answer");

	// Register writes; a CTRL write of a nonzero op issues one instruction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `TPO_RESP_OKAY;
			work_reg <= '0;
			carry_reg <= 1'b0;
			op_reg <= TPO_NONE;
		end else begin
			op_reg <= TPO_NONE;
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= `TPO_RESP_OKAY;
				case ({awaddr_reg[11:2], 2'b00})
					`TPO_OFF_CTRL: begin
						if (wstrb_reg[0]) begin
							op_reg <= tpo_op_type'(wdata_reg[2:0]);
						end
					end
					`TPO_OFF_AB: begin
						if (wstrb_reg[0]) begin
							work_reg.acc <= wdata_reg[3:0];
							work_reg.reg_b <= wdata_reg[7:4];
						end
						if (wstrb_reg[1]) begin
							carry_reg <= wdata_reg[8];
						end
					end
					default: bresp_reg <= `TPO_RESP_SLVERR;
				endcase
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	sequence s_ctrl_issue;
		wr_go && {awaddr_reg[11:2], 2'b00} == `TPO_OFF_CTRL && wstrb_reg[0]
			&& wdata_reg[2:0] != `TPO_OP_NONE;
	endsequence
	sequence s_issue_then_done;
		op_reg != TPO_NONE ##1 done && op_reg == TPO_NONE;
	endsequence
	sequence s_bad_write;
		wr_go && {awaddr_reg[11:2], 2'b00} != `TPO_OFF_CTRL
			&& {awaddr_reg[11:2], 2'b00} != `TPO_OFF_AB;
	endsequence

	// One control write, one instruction, one cycle
	a_ctrl_issues_op: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ctrl_issue |=> s_issue_then_done)
		else $error("control write did not execute in one cycle");
	a_op_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg != TPO_NONE |=> op_reg == TPO_NONE)
		else $error("instruction strobe longer than one cycle");
	a_carry_by_op: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg != TPO_NONE |=> $stable(carry_reg))
		else $error("carry changed by a transfer");
	a_bad_write_err: assert property (@(posedge aclk) disable iff (!aresetn)
		s_bad_write |=> s_axi_bresp == `TPO_RESP_SLVERR)
		else $error("write to read-only register not refused");
	a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	// Skip never raised by these ops; kept as observable state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			skip_reg <= 1'b0;
			count_reg <= 8'h00;
		end else begin
			skip_reg <= flags_o.skip;
			if (done) begin
				count_reg <= count_reg + 8'h01;
			end
		end
	end

	// Count wraps after 256 instructions; software reads differences
	a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
		done |=> count_reg == $past(count_reg) + 8'h01)
		else $error("executed-op count did not step");
	a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!done |=> $stable(count_reg))
		else $error("executed-op count moved without an op");
	a_skip_low: assert property (@(posedge aclk) disable iff (!aresetn)
		!skip_reg)
		else $error("skip raised by a transfer");

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `TPO_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= `TPO_RESP_OKAY;
			case ({s_axi_araddr[11:2], 2'b00})
				`TPO_OFF_CTRL: rdata_reg <= {29'h0, op_reg};
				`TPO_OFF_AB: rdata_reg <= {23'h0, carry_reg, work_reg.reg_b, work_reg.acc};
				`TPO_OFF_PS: rdata_reg <= {16'h0, regs.prescaler_reload_reg,
					regs.prescaler_counter};
				`TPO_OFF_PU: rdata_reg <= {24'h0, regs.pullup_ctrl_reg1, regs.pullup_ctrl_reg0};
				`TPO_OFF_R1: rdata_reg <= {24'h0, regs.timer1_reload_reg};
				`TPO_OFF_STAT: rdata_reg <= {22'h0, count_reg, skip_reg, flags_o.carry};
				default: begin
					rdata_reg <= 32'h00000000;
					rresp_reg <= `TPO_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	sequence s_read_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_read_unmapped;
		s_axi_arvalid && s_axi_arready && {s_axi_araddr[11:2], 2'b00} > `TPO_OFF_STAT;
	endsequence

	// A read answer stands with its data until the master takes it
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_read_take |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
			&& $stable(s_axi_rresp))
		else $error("read data dropped before taken");
	a_ar_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while busy");
	a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
		s_read_unmapped |=> s_axi_rresp == `TPO_RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");

	tpo_exec tpo_exec_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.op(op_reg),
		.work(work_reg),
		.flags_in({carry_reg, 1'b0}),
		.regs(regs),
		.flags_out(flags_o),
		.done(done)
	);

	sequence s_ps_issue;
		op_reg == TPO_LOAD_PRESCALER_FROM_AB;
	endsequence
	sequence s_r1_issue;
		op_reg == TPO_LOAD_TIMER1_RELOAD_FROM_AB;
	endsequence

	a_ps_high_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ps_issue |=> regs.prescaler_counter[7:4] == $past(work_reg.reg_b)
			&& regs.prescaler_reload_reg[7:4] == $past(work_reg.reg_b))
		else $error("prescaler high nibble not from B");
	a_ps_low_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ps_issue |=> regs.prescaler_counter[3:0] == $past(work_reg.acc)
			&& regs.prescaler_reload_reg[3:0] == $past(work_reg.acc))
		else $error("prescaler low nibble not from A");
	a_pu0_load: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg == TPO_LOAD_PULLUP_CTRL0 |=> regs.pullup_ctrl_reg0 == $past(work_reg.acc))
		else $error("pull-up reg0 not loaded");
	a_pu1_load: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg == TPO_LOAD_PULLUP_CTRL1 |=> regs.pullup_ctrl_reg1 == $past(work_reg.acc))
		else $error("pull-up reg1 not loaded");
	a_r1_high: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r1_issue |=> regs.timer1_reload_reg[7:4] == $past(work_reg.reg_b))
		else $error("timer1 reload high nibble wrong");
	a_r1_low: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r1_issue |=> regs.timer1_reload_reg[3:0] == $past(work_reg.acc))
		else $error("timer1 reload low nibble wrong");
	a_one_cycle_done: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg != TPO_NONE |=> done ##1 !done || op_reg != TPO_NONE)
		else $error("transfer not done in one cycle");
	a_carry_kept: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg != TPO_NONE |=> flags_o.carry == $past(carry_reg) && !flags_o.skip)
		else $error("carry changed or skip raised");
	a_pu_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg == TPO_NONE |=> $stable(regs.pullup_ctrl_reg0) && $stable(regs.pullup_ctrl_reg1))
		else $error("pull-up changed without op");

	// No op may touch a register it does not target
	a_ps_isolated: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg != TPO_LOAD_PRESCALER_FROM_AB |=> $stable(regs.prescaler_counter)
			&& $stable(regs.prescaler_reload_reg))
		else $error("prescaler changed by another op");
	a_pu0_isolated: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg != TPO_LOAD_PULLUP_CTRL0 |=> $stable(regs.pullup_ctrl_reg0))
		else $error("pull-up reg0 changed by another op");
	a_pu1_isolated: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg != TPO_LOAD_PULLUP_CTRL1 |=> $stable(regs.pullup_ctrl_reg1))
		else $error("pull-up reg1 changed by another op");
	a_r1_isolated: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg != TPO_LOAD_TIMER1_RELOAD_FROM_AB |=> $stable(regs.timer1_reload_reg))
		else $error("timer1 reload changed by another op");
	a_done_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		op_reg == TPO_NONE |=> !done)
		else $error("done raised without an op");
	a_reset_idle: assert property (@(posedge aclk)
		!aresetn |=> !s_axi_bvalid && !s_axi_rvalid && op_reg == TPO_NONE)
		else $error("bus or strobe busy after reset");
endmodule
`default_nettype wire

/* tpo_defs.svh */
// Constants for the accumulator-transfer execution block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TPO_DEFS_SVH
`define TPO_DEFS_SVH
`define TPO_NIB_W 4
`define TPO_BYTE_W 8
`define TPO_PS_RESET 8'hFF
`define TPO_R1_RESET 8'hFF
`define TPO_PU_RESET 4'h0
// Register map, byte addresses
`define TPO_OFF_CTRL 12'h000
`define TPO_OFF_AB 12'h004
`define TPO_OFF_PS 12'h008
`define TPO_OFF_PU 12'h00C
`define TPO_OFF_R1 12'h010
`define TPO_OFF_STAT 12'h014
`define TPO_OP_NONE 3'h0
`define TPO_OP_PS 3'h1
`define TPO_OP_PU0 3'h2
`define TPO_OP_PU1 3'h3
`define TPO_OP_R1 3'h4
`define TPO_RESP_OKAY 2'h0
`define TPO_RESP_SLVERR 2'h2
`endif

/* tpo_pkg.sv */
// Types for the accumulator-transfer execution block.
// Assumes tpo_defs.svh is on the include path.
`include "tpo_defs.svh"
package tpo_pkg;
	typedef enum logic [2:0] {
		TPO_NONE = `TPO_OP_NONE,
		TPO_LOAD_PRESCALER_FROM_AB = `TPO_OP_PS,
		TPO_LOAD_PULLUP_CTRL0 = `TPO_OP_PU0,
		TPO_LOAD_PULLUP_CTRL1 = `TPO_OP_PU1,
		TPO_LOAD_TIMER1_RELOAD_FROM_AB = `TPO_OP_R1
	} tpo_op_type;
	typedef struct packed {
		logic [3:0] acc;
		logic [3:0] reg_b;
	} tpo_work_type;
	typedef struct packed {
		logic [7:0] prescaler_counter;
		logic [7:0] prescaler_reload_reg;
		logic [3:0] pullup_ctrl_reg0;
		logic [3:0] pullup_ctrl_reg1;
		logic [7:0] timer1_reload_reg;
	} tpo_regs_type;
	typedef struct packed {
		logic carry;
		logic skip;
	} tpo_flags_type;
endpackage

/* tpo_exec.sv */
// Executes one transfer instruction per cycle into the target registers.
// Assumes op is a one-cycle strobe from the decode stage, same clock.
`timescale 1ns/1ps
`default_nettype none
`include "tpo_defs.svh"
module tpo_exec (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire tpo_pkg::tpo_op_type op, // Decoded op, one cycle
	input wire tpo_pkg::tpo_work_type work, // A and B
	input wire tpo_pkg::tpo_flags_type flags_in, // Carry, skip in
	output tpo_pkg::tpo_regs_type regs, // Target registers
	output tpo_pkg::tpo_flags_type flags_out, // Carry, skip out
	output logic done // Op executed this cycle
);
	import tpo_pkg::*;
	tpo_regs_type regs_reg;
	tpo_flags_type flags_reg;
	logic done_reg;
	assign regs = regs_reg;
	assign flags_out = flags_reg;
	assign done = done_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			regs_reg.prescaler_counter <= `TPO_PS_RESET;
			regs_reg.prescaler_reload_reg <= `TPO_PS_RESET;
			regs_reg.pullup_ctrl_reg0 <= `TPO_PU_RESET;
			regs_reg.pullup_ctrl_reg1 <= `TPO_PU_RESET;
			regs_reg.timer1_reload_reg <= `TPO_R1_RESET;
		end else begin
			unique case (op)
				TPO_LOAD_PRESCALER_FROM_AB: begin
					regs_reg.prescaler_counter <= {work.reg_b, work.acc};
					regs_reg.prescaler_reload_reg <= {work.reg_b, work.acc};
				end
				TPO_LOAD_PULLUP_CTRL0: regs_reg.pullup_ctrl_reg0 <= work.acc;
				TPO_LOAD_PULLUP_CTRL1: regs_reg.pullup_ctrl_reg1 <= work.acc;
				TPO_LOAD_TIMER1_RELOAD_FROM_AB: begin
					regs_reg.timer1_reload_reg <= {work.reg_b, work.acc};
				end
				TPO_NONE: ;
				default: ;
			endcase
		end
	end

	// Flags pass through untouched; no transfer can set skip
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			flags_reg <= flags_in;
			done_reg <= (op != TPO_NONE);
		end
	end
endmodule
`default_nettype wire

/* tpo_top_test.sv */
// Self-checking bench for the AXI4-Lite transfer-instruction block.
// Assumes tpo_pkg and tpo_defs.svh are compiled and on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "tpo_defs.svh"
module tpo_top_test;
	import tpo_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	tpo_regs_type regs;
	logic carry_out;
	int errors = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic [1:0] rsp;

	always #2.5 aclk = ~aclk;

	tpo_top tpo_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .regs(regs), .carry_out(carry_out));

	task automatic tally_and_finish();
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Handshakes judged at the falling edge, so ready is settled before the rising edge
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_left;
		logic w_left;
		logic a_hit;
		logic w_hit;
		logic b_hit;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_left = 1'b1;
		w_left = 1'b1;
		while (aw_left || w_left) begin
			@(negedge aclk);
			a_hit = aw_left && awready;
			w_hit = w_left && wready;
			@(posedge aclk);
			if (a_hit) begin
				awvalid <= 1'b0;
				aw_left = 1'b0;
			end
			if (w_hit) begin
				wvalid <= 1'b0;
				w_left = 1'b0;
			end
		end
		b_hit = 1'b0;
		while (!b_hit) begin
			@(negedge aclk);
			b_hit = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic hit;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hit = 1'b0;
		while (!hit) begin
			@(negedge aclk);
			hit = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		hit = 1'b0;
		while (!hit) begin
			@(negedge aclk);
			hit = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask

	// Loads A, B and carry, then issues one transfer instruction
	task automatic run_op(input logic [3:0] a, input logic [3:0] b, input logic c,
		input logic [2:0] op);
		axi_write(`TPO_OFF_AB, {23'h0, c, b, a}, rsp);
		chk({30'h0, rsp}, {30'h0, `TPO_RESP_OKAY});
		axi_write(`TPO_OFF_CTRL, {29'h0, op}, rsp);
		chk({30'h0, rsp}, {30'h0, `TPO_RESP_OKAY});
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		axi_read(a, rd, rsp);
		chk(rd, exp);
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(`TPO_OFF_PS, 32'h0000FFFF);
		rd_chk(`TPO_OFF_PU, 32'h00000000);
		rd_chk(`TPO_OFF_R1, 32'h000000FF);
		run_op(4'h5, 4'hA, 1'b1, `TPO_OP_PS);
		rd_chk(`TPO_OFF_PS, 32'h0000A5A5);
		chk({24'h0, regs.prescaler_counter}, 32'h000000A5);
		chk({24'h0, regs.prescaler_reload_reg}, 32'h000000A5);
		// Extreme nibbles catch a swapped half
		run_op(4'h0, 4'hF, 1'b1, `TPO_OP_R1);
		rd_chk(`TPO_OFF_R1, 32'h000000F0);
		rd_chk(`TPO_OFF_PS, 32'h0000A5A5);
		run_op(4'h3, 4'hE, 1'b1, `TPO_OP_PU0);
		rd_chk(`TPO_OFF_PU, 32'h00000003);
		run_op(4'hC, 4'h1, 1'b1, `TPO_OP_PU1);
		rd_chk(`TPO_OFF_PU, 32'h000000C3);
		chk({28'h0, regs.pullup_ctrl_reg0}, 32'h00000003);
		chk({28'h0, regs.pullup_ctrl_reg1}, 32'h0000000C);
		chk({31'h0, carry_out}, 32'h00000001);
		rd_chk(`TPO_OFF_STAT, 32'h00000011);
		run_op(4'hF, 4'h7, 1'b0, `TPO_OP_R1);
		rd_chk(`TPO_OFF_R1, 32'h0000007F);
		chk({24'h0, regs.timer1_reload_reg}, 32'h0000007F);
		rd_chk(`TPO_OFF_STAT, 32'h00000014);
		chk({31'h0, carry_out}, 32'h00000000);
		rd_chk(`TPO_OFF_CTRL, 32'h00000000);
		axi_write(`TPO_OFF_CTRL, 32'h00000000, rsp);
		chk({30'h0, rsp}, {30'h0, `TPO_RESP_OKAY});
		axi_read(12'h100, rd, rsp);
		chk({30'h0, rsp}, {30'h0, `TPO_RESP_SLVERR});
		chk(rd, 32'h0);
		axi_write(`TPO_OFF_STAT, 32'h0000FFFF, rsp);
		chk({30'h0, rsp}, {30'h0, `TPO_RESP_SLVERR});
		rd_chk(`TPO_OFF_STAT, 32'h00000014);
		tally_and_finish();
	end
endmodule
`default_nettype wire
